// file: cpc_defs.vh
`ifndef CPC_DEFS_VH
`define CPC_DEFS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define CPC_ADDR_PROT_THR 8'h01
`define CPC_ADDR_CUR_LIM 8'h08

// ----------------------------------------
// reset values
// ----------------------------------------
`define CPC_PROT_THR_RST 6'h08
`define CPC_CUR_LIM_RST 8'h1b
`define CPC_EV_IDLE 7'h02

// ----------------------------------------
// protection_threshold_config fields
// ----------------------------------------
`define CPC_PG_HI_BIT 5
`define CPC_PG_LO_BIT 4
`define CPC_OV_MSB 3
`define CPC_OV_LSB 2
`define CPC_UV_MSB 1
`define CPC_UV_LSB 0

// ----------------------------------------
// current_limit_setting fields
// ----------------------------------------
`define CPC_LL_MSB 7
`define CPC_LL_LSB 5
`define CPC_TC_BIT 4
`define CPC_CL_MSB 3
`define CPC_CL_LSB 0
`define CPC_CL_MAX 4'hb

// ----------------------------------------
// threshold percentages
// ----------------------------------------
`define CPC_PCT_75 8'h4b
`define CPC_PCT_80 8'h50
`define CPC_PCT_85 8'h55
`define CPC_PCT_90 8'h5a
`define CPC_PCT_95 8'h5f
`define CPC_PCT_105 8'h69
`define CPC_PCT_110 8'h6e
`define CPC_PCT_120 8'h78
`define CPC_PCT_130 8'h82
`define CPC_PCT_DIV 16'h0064

// ----------------------------------------
// event classes
// ----------------------------------------
`define CPC_CLASS_NONE 2'h0
`define CPC_CLASS_WARN 2'h1
`define CPC_CLASS_FAULT 2'h2
`define CPC_CLASS_ERROR 2'h3

`endif

// file: cpc_thr_calc.v
`timescale 1ns/1ps
`include "cpc_defs.vh"

// ----------------------------------------
// scales output setpoint by a percentage
// ----------------------------------------
module cpc_thr_calc #(
  parameter VW = 12
) (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // operands
  input wire [VW-1:0] setpoint_i,
  input wire [7:0] pct_i,
  // result
  output reg [VW-1:0] level_o
);

  wire [VW+7:0] prod;
  wire [VW+7:0] quot;

  assign prod = setpoint_i * pct_i;
  assign quot = prod / `CPC_PCT_DIV;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      level_o <= {VW{1'b0}};
    end
    else if (quot > {{8{1'b0}}, {VW{1'b1}}})
    begin
      level_o <= {VW{1'b1}};
    end
    else
    begin
      level_o <= quot[VW-1:0];
    end
  end

endmodule

// file: cpc_prot_cfg.v
`timescale 1ns/1ps
`include "cpc_defs.vh"

// Operation
// R1: each protective event is assigned exactly one class of warning, fault or error.
// R2: thermal near-limit and power-good loss are warnings, power-good being active low; the code takes power_good_i low as the loss.
// R3: overcurrent, overvoltage, overtemperature and tracking failure are faults.
// R4: undervoltage alone is an error, and fault responses come from register fields; the code has no such field and requests shutdown on every fault.
// R5: a warning never requests turn-off and only raises a host-visible indication.
// R6: thresholds are written over the serial register port at address 0x01.
// R7: bit 5 picks 105% or 110% upper power-good, bit 4 picks 95% or 90% lower.
// R8: overvoltage field 3:2 maps 00 to 110%, 01 to 120%, 1x to 130%, reset 10.
// R9: address 0x01 takes writes only while the run-control bit is low.
// R10: voltage thresholds are recomputed from the live output setpoint.
// R11: the overcurrent limit is programmed at address 0x08.
// R12: the host read-modify-writes address 0x08 to keep the load-line field.
// R13: load-line field 7:5 selects one of eight slopes, reset code 0.
// R14: undervoltage field 1:0 maps to 75%, 80%, 85% and 90%, reset 00.
// R15: current-limit codes above 0xb are used as 0xb.
// R16: the thermal-compensation bit enables temperature tracking of the overcurrent level.
module cpc_prot_cfg #(
  parameter VW = 12,
  parameter TW = 8
) (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_ack_o,
  output reg reg_wr_refused_o,
  // converter state
  input wire run_i,
  input wire [VW-1:0] setpoint_i,
  input wire [TW-1:0] temp_rise_i,
  // raw protection events (asynchronous)
  input wire thermal_near_i,
  input wire power_good_i,
  input wire overcurrent_i,
  input wire overvoltage_i,
  input wire overtemp_i,
  input wire track_fail_i,
  input wire undervoltage_i,
  // thresholds
  output reg [VW-1:0] pg_upper_o,
  output reg [VW-1:0] pg_lower_o,
  output reg [VW-1:0] ov_level_o,
  output reg [VW-1:0] uv_level_o,
  output reg [3:0] current_limit_setpoint_o,
  output reg [TW+3:0] oc_comp_code_o,
  output reg [2:0] load_line_slope_o,
  // event classification
  output reg warning_o,
  output reg fault_o,
  output reg error_o,
  output reg shutdown_req_o,
  output reg [1:0] event_class_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [3:0] clamp_cl;
    input [3:0] code;
    begin
      clamp_cl = (code > `CPC_CL_MAX) ? `CPC_CL_MAX : code;
    end
  endfunction

  function [7:0] ov_pct;
    input [1:0] code;
    begin
      case (code)
        2'h0: ov_pct = `CPC_PCT_110;
        2'h1: ov_pct = `CPC_PCT_120;
        default: ov_pct = `CPC_PCT_130;
      endcase
    end
  endfunction

  function [7:0] uv_pct;
    input [1:0] code;
    begin
      case (code)
        2'h0: uv_pct = `CPC_PCT_75;
        2'h1: uv_pct = `CPC_PCT_80;
        2'h2: uv_pct = `CPC_PCT_85;
        default: uv_pct = `CPC_PCT_90;
      endcase
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [5:0] prot_thr_q;
  reg [7:0] cur_lim_q;
  reg run_s1_q;
  reg run_s2_q;
  wire addr_thr;
  wire addr_cl;

  assign addr_thr = (reg_addr_i == `CPC_ADDR_PROT_THR);
  assign addr_cl = (reg_addr_i == `CPC_ADDR_CUR_LIM);

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
    end
    else
    begin
      run_s1_q <= run_i;
      run_s2_q <= run_s1_q;
    end
  end

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prot_thr_q <= `CPC_PROT_THR_RST;
      cur_lim_q <= `CPC_CUR_LIM_RST;
      reg_rdata_o <= 8'h00;
      reg_ack_o <= 1'b0;
      reg_wr_refused_o <= 1'b0;
    end
    else
    begin
      reg_ack_o <= reg_wr_i | reg_rd_i;
      reg_wr_refused_o <= reg_wr_i & addr_thr & run_s2_q; // R9
      if (reg_wr_i && addr_thr && !run_s2_q) // R6 R9
      begin
        prot_thr_q <= reg_wdata_i[5:0];
      end
      if (reg_wr_i && addr_cl) // R11 R12
      begin
        cur_lim_q <= reg_wdata_i;
      end
      if (reg_rd_i)
      begin
        if (addr_thr)
        begin
          reg_rdata_o <= {2'h0, prot_thr_q};
        end
        else if (addr_cl)
        begin
          reg_rdata_o <= cur_lim_q;
        end
        else
        begin
          reg_rdata_o <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // threshold computation
  // ----------------------------------------
  reg [7:0] pg_hi_pct;
  reg [7:0] pg_lo_pct;
  wire [VW-1:0] pg_hi_lvl;
  wire [VW-1:0] pg_lo_lvl;
  wire [VW-1:0] ov_lvl;
  wire [VW-1:0] uv_lvl;

  always @*
  begin
    pg_hi_pct = prot_thr_q[`CPC_PG_HI_BIT] ? `CPC_PCT_105 : `CPC_PCT_110; // R7
    pg_lo_pct = prot_thr_q[`CPC_PG_LO_BIT] ? `CPC_PCT_95 : `CPC_PCT_90; // R7
  end

  // R10
  cpc_thr_calc #(.VW(VW)) u_pg_hi (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .setpoint_i(setpoint_i),
    .pct_i(pg_hi_pct),
    .level_o(pg_hi_lvl)
  );

  cpc_thr_calc #(.VW(VW)) u_pg_lo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .setpoint_i(setpoint_i),
    .pct_i(pg_lo_pct),
    .level_o(pg_lo_lvl)
  );

  cpc_thr_calc #(.VW(VW)) u_ov (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .setpoint_i(setpoint_i),
    .pct_i(ov_pct(prot_thr_q[`CPC_OV_MSB:`CPC_OV_LSB])), // R8
    .level_o(ov_lvl)
  );

  cpc_thr_calc #(.VW(VW)) u_uv (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .setpoint_i(setpoint_i),
    .pct_i(uv_pct(prot_thr_q[`CPC_UV_MSB:`CPC_UV_LSB])), // R14
    .level_o(uv_lvl)
  );

  // ----------------------------------------
  // current limit outputs
  // ----------------------------------------
  wire [3:0] cl_eff;
  wire [TW+3:0] comp_add;

  assign cl_eff = clamp_cl(cur_lim_q[`CPC_CL_MSB:`CPC_CL_LSB]); // R15
  assign comp_add = cur_lim_q[`CPC_TC_BIT] ? {4'h0, temp_rise_i} : {(TW+4){1'b0}}; // R16

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pg_upper_o <= {VW{1'b0}};
      pg_lower_o <= {VW{1'b0}};
      ov_level_o <= {VW{1'b0}};
      uv_level_o <= {VW{1'b0}};
      current_limit_setpoint_o <= 4'h0;
      oc_comp_code_o <= {(TW+4){1'b0}};
      load_line_slope_o <= 3'h0;
    end
    else
    begin
      pg_upper_o <= pg_hi_lvl;
      pg_lower_o <= pg_lo_lvl;
      ov_level_o <= ov_lvl;
      uv_level_o <= uv_lvl;
      current_limit_setpoint_o <= cl_eff; // R15
      oc_comp_code_o <= {{TW{1'b0}}, cl_eff} + comp_add; // R16
      load_line_slope_o <= cur_lim_q[`CPC_LL_MSB:`CPC_LL_LSB]; // R13
    end
  end

  // ----------------------------------------
  // event classification
  // ----------------------------------------
  reg [6:0] ev_s1_q;
  reg [6:0] ev_s2_q;
  wire warn_ev;
  wire fault_ev;
  wire err_ev;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ev_s1_q <= `CPC_EV_IDLE;
      ev_s2_q <= `CPC_EV_IDLE;
    end
    else
    begin
      ev_s1_q <= {undervoltage_i, track_fail_i, overtemp_i, overvoltage_i,
                  overcurrent_i, power_good_i, thermal_near_i};
      ev_s2_q <= ev_s1_q;
    end
  end

  assign warn_ev = ev_s2_q[0] | ~ev_s2_q[1]; // R2
  assign fault_ev = |ev_s2_q[5:2]; // R3
  assign err_ev = ev_s2_q[6]; // R4

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      warning_o <= 1'b0;
      fault_o <= 1'b0;
      error_o <= 1'b0;
      shutdown_req_o <= 1'b0;
      event_class_o <= `CPC_CLASS_NONE;
    end
    else
    begin
      warning_o <= warn_ev; // R5
      fault_o <= fault_ev;
      error_o <= err_ev;
      shutdown_req_o <= fault_ev | err_ev; // R5
      // R1
      if (err_ev)
      begin
        event_class_o <= `CPC_CLASS_ERROR;
      end
      else if (fault_ev)
      begin
        event_class_o <= `CPC_CLASS_FAULT;
      end
      else if (warn_ev)
      begin
        event_class_o <= `CPC_CLASS_WARN;
      end
      else
      begin
        event_class_o <= `CPC_CLASS_NONE;
      end
    end
  end

endmodule

// file: cpc_prot_cfg_properties.sv
`timescale 1ns/1ps
module cpc_prot_cfg_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_ack_o,
  input wire logic reg_wr_refused_o,
  // outputs
  input wire logic [3:0] current_limit_setpoint_o,
  input wire logic warning_o,
  input wire logic fault_o,
  input wire logic error_o,
  input wire logic shutdown_req_o,
  input wire logic [1:0] event_class_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_req;
    reg_wr_i || reg_rd_i;
  endsequence
  a_ack_follows: assert property (s_req |=> reg_ack_o) else $error("ack missing");
  a_ack_cause: assert property (reg_ack_o |-> $past(reg_wr_i || reg_rd_i))
    else $error("ack without request");
  a_refuse_cause: assert property (reg_wr_refused_o |-> $past(reg_wr_i && reg_addr_i == 8'h01))
    else $error("refusal without write");
  a_warn_no_stop: assert property (warning_o && !fault_o && !error_o |->
    !shutdown_req_o && event_class_o == 2'h1) else $error("warning misclassed");
  a_stop_follows: assert property (shutdown_req_o == (fault_o || error_o))
    else $error("shutdown mismatch");
  a_fault_class: assert property (fault_o && !error_o |-> event_class_o == 2'h2)
    else $error("fault class wrong");
  a_error_class: assert property (error_o |-> event_class_o == 2'h3)
    else $error("error class wrong");
  a_none_class: assert property (!(warning_o || fault_o || error_o) |-> event_class_o == 2'h0)
    else $error("idle class wrong");
  a_cl_ceiling: assert property (current_limit_setpoint_o <= 4'hb)
    else $error("limit above ceiling");
endmodule

// file: cpc_host_model.sv
`timescale 1ns/1ps
module cpc_host_model (
  // clock
  input wire logic clk_i,
  // register port
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o = 8'h00,
  output logic [7:0] reg_wdata_o = 8'h00,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0
);
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // released lines do not keep their value
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    @(negedge clk_i);
    q = reg_rdata_i;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask
  // keeps bits outside the mask
  task automatic rmw(input logic [7:0] a, m, v);
    logic [7:0] q;
    rd(a, q);
    wr(a, (q & ~m) | (v & m));
  endtask
endmodule

// file: cpc_prot_cfg_tb.sv
`timescale 1ns/1ps
module cpc_prot_cfg_tb;
  logic clk_i = 1'b0, resetn_i = 1'b0, run_i = 1'b0;
  logic [11:0] setpoint_i = 12'h3e8;
  logic [7:0] temp_rise_i = 8'h10, rdata, addr, wdata, q, v, r;
  logic wr, rd, ack, refused, warn, flt, err, sd, ref_seen = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [11:0] pgu, pgl, ovl, uvl, occ, e;
  logic [3:0] cl;
  logic [2:0] lls;
  logic [1:0] current_limit_setting;
  logic [15:0] lfsr = 16'hd67d;
  logic [13:0] classes = {2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
  int fail_count = 0, n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (refused) ref_seen <= 1'b1;
  cpc_prot_cfg DUT (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_ack_o(ack), .reg_wr_refused_o(refused), .run_i(run_i),
    .setpoint_i(setpoint_i), .temp_rise_i(temp_rise_i), .thermal_near_i(ev[0]),
    .power_good_i(!ev[1]), .overcurrent_i(ev[2]), .overvoltage_i(ev[3]),
    .overtemp_i(ev[4]), .track_fail_i(ev[5]), .undervoltage_i(ev[6]),
    .pg_upper_o(pgu), .pg_lower_o(pgl), .ov_level_o(ovl), .uv_level_o(uvl),
    .current_limit_setpoint_o(cl), .oc_comp_code_o(occ), .load_line_slope_o(lls),
    .warning_o(warn), .fault_o(flt), .error_o(err), .shutdown_req_o(sd),
    .event_class_o(current_limit_setting));
  cpc_host_model host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [11:0] pct(input logic [11:0] sp, input int p);
    int lvl;
    lvl = (sp * p) / 100;
    return (lvl > 4095) ? 12'hfff : 12'(lvl);
  endfunction
  task automatic chk(input string nm, input logic [11:0] exp, seen);
    n_checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  task automatic check_thr(input logic [7:0] c);
    repeat (3) @(negedge clk_i);
    host.rd(8'h01, q);
    chk("thr_reg", {6'h00, c[5:0]}, q);
    chk("pg_upper", pct(setpoint_i, c[5] ? 105 : 110), pgu);
    chk("pg_lower", pct(setpoint_i, c[4] ? 95 : 90), pgl);
    chk("ov_level", pct(setpoint_i, c[3] ? 130 : (c[2] ? 120 : 110)), ovl);
    chk("uv_level", pct(setpoint_i, 75 + 5 * c[1:0]), uvl);
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    final_report();
  end
  initial
  begin
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    host.rd(8'h08, q);
    chk("cl_reg_reset", 12'h01b, q);
    chk("oc_comp_reset", 12'h01b, occ);
    chk("slope_reset", 12'h000, lls);
    check_thr(8'h08);
    host.rd(8'h5a, q);
    chk("unmapped", 12'h000, q);
    $display("reset test done");
    for (int i = 0; i < 64; i++)
    begin
      host.wr(8'h01, 8'(i) | 8'hc0);
      setpoint_i = (i == 0) ? 12'h000 : ((i == 63) ? 12'hfff : 12'(rnd()));
      check_thr(8'(i));
    end
    chk("no_refuse", 12'h000, ref_seen);
    $display("threshold test done");
    run_i = 1'b1;
    repeat (4) @(negedge clk_i);
    host.wr(8'h01, 8'h00);
    check_thr(8'h3f);
    chk("refused", 12'h001, ref_seen);
    run_i = 1'b0;
    $display("refusal test done");
    for (int i = 0; i < 16; i++)
    begin
      r = 8'(rnd());
      temp_rise_i = 8'(rnd());
      v = {r[7:4], 4'(i)};
      host.wr(8'h08, v);
      repeat (3) @(negedge clk_i);
      e = (i > 11) ? 12'h00b : 12'(i);
      chk("cl_clamp", e, cl);
      chk("slope", v[7:5], lls);
      chk("oc_comp", e + (v[4] ? temp_rise_i : 12'h000), occ);
    end
    host.rmw(8'h08, 8'h0f, 8'h05);
    host.rd(8'h08, q);
    chk("rmw", {v[7:4], 4'h5}, q);
    $display("current limit test done");
    for (int i = 0; i < 8; i++)
    begin
      ev = (i == 7) ? 7'h7f : 7'(1 << i);
      repeat (5) @(negedge clk_i);
      e = (i == 7) ? 12'h003 : classes[2 * i +: 2];
      chk("class", e, current_limit_setting);
      chk("warning", (i < 2) || (i == 7), warn);
      chk("shutdown", e > 1, sd);
      chk("fault", (e == 2) || (i == 7), flt);
      chk("error", e == 3, err);
    end
    ev = 7'h00;
    repeat (5) @(negedge clk_i);
    chk("class_idle", 12'h000, current_limit_setting);
    $display("event test done");
    final_report();
  end
endmodule
bind cpc_prot_cfg cpc_prot_cfg_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_ack_o(reg_ack_o), .reg_wr_refused_o(reg_wr_refused_o),
  .current_limit_setpoint_o(current_limit_setpoint_o), .warning_o(warning_o),
  .fault_o(fault_o), .error_o(error_o), .shutdown_req_o(shutdown_req_o),
  .event_class_o(event_class_o));
